// ==== hdl/pin_mux_pkg.sv ====
// shared constants and carrier types for the low-pin function selector
package pin_mux_pkg;

    localparam int pin_count = 5;
    localparam int code_width = 5;
    localparam logic [4:0] analog_code = 5'h1f;

    // register byte offsets
    localparam logic [11:0] dir_offset = 12'h000;
    localparam logic [11:0] sel_offset = 12'h004;
    localparam logic [11:0] lcd_offset = 12'h008;
    localparam logic [11:0] map0_offset = 12'h00c;
    localparam logic [11:0] state_offset = 12'h020;

    // values after reset
    localparam logic [4:0] dir_reset = 5'h00;
    localparam logic [4:0] sel_reset = 5'h00;
    localparam logic [4:0] lcd_reset = 5'h00;
    localparam logic [4:0] map_reset = 5'h00;

    // status field positions
    localparam int state_lcd_pos = 0;
    localparam int state_analog_pos = 8;
    localparam int state_mapped_pos = 16;
    localparam int state_out_pos = 24;

    localparam logic [1:0] resp_okay = 2'b00;
    localparam logic [1:0] resp_slverr = 2'b10;

    // per-pin peripheral side signals
    typedef struct packed {
        logic [pin_count-1:0] out;
        logic [pin_count-1:0] oe;
    } drive_type;

    // per-pin pad signals
    typedef struct packed {
        logic [pin_count-1:0] out;
        logic [pin_count-1:0] oe;
        logic [pin_count-1:0] in_enable;
    } pad_type;

endpackage : pin_mux_pkg

// ==== hdl/port_one_low_pin_function_select.sv ====
// function selector and axi4-lite register file for five port pins
//
// Implementation choices: the address map and the AXI4-Lite register port.
module port_one_low_pin_function_select
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [pin_mux_pkg::pin_count-1:0] gpio_out,
    output logic [pin_mux_pkg::pin_count-1:0] gpio_in,
    input wire pin_mux_pkg::drive_type mapped_drive,
    output logic [pin_mux_pkg::pin_count-1:0] mapped_in,
    input wire logic [pin_mux_pkg::pin_count-1:0] lcd_segment_line,
    output pin_mux_pkg::pad_type pad,
    input wire logic [pin_mux_pkg::pin_count-1:0] pad_in
);
    import pin_mux_pkg::*;

    typedef enum logic [3:0]
    {
        fn_gpio = 4'b0001,
        fn_mapped = 4'b0010,
        fn_analog = 4'b0100,
        fn_lcd = 4'b1000
    } function_type;

    logic [pin_count-1:0] pin_direction_bit_reg;
    logic [pin_count-1:0] pin_function_select_bit_reg;
    logic [pin_count-1:0] lcd_segment_enable_reg;
    logic [code_width-1:0] pin_mapping_code_reg [pin_count];
    logic [11:0] awaddr_reg;
    logic aw_held_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic w_held_reg;
    logic aw_held_next;
    logic w_held_next;
    logic bvalid_next;
    logic [31:0] read_word;
    logic read_hit;
    logic write_hit;
    logic [pin_count-1:0] is_lcd;
    logic [pin_count-1:0] is_analog;
    logic [pin_count-1:0] is_mapped;
    logic [pin_count-1:0] is_out;
    pad_type pad_next;
    logic [pin_count-1:0] gpio_in_next;
    logic [pin_count-1:0] mapped_in_next;

    // decode one pin's function from its control bits
    function automatic function_type pick_function(input logic sel, input logic lcd,
        input logic [code_width-1:0] code);
        if (lcd)
            return fn_lcd;
        else if (!sel)
            return fn_gpio;
        else if (code == analog_code)
            return fn_analog;
        else
            return fn_mapped;
    endfunction : pick_function

    // flag whether an aligned address names a register
    function automatic logic map_hit(input logic [11:0] addr, input logic allow_state);
        logic hit;
        hit = 1'b0;
        if (addr[1:0] == 2'b00)
        begin
            if (addr == dir_offset || addr == sel_offset || addr == lcd_offset)
                hit = 1'b1;
            else if (addr >= map0_offset && addr < map0_offset + 12'(4 * pin_count))
                hit = 1'b1;
            else if (allow_state && addr == state_offset)
                hit = 1'b1;
        end
        return hit;
    endfunction : map_hit

    genvar g;
    generate
        for (g = 0; g < pin_count; g = g + 1)
        begin : g_pin
            function_type fn;
            assign fn = pick_function(pin_function_select_bit_reg[g],
                lcd_segment_enable_reg[g], pin_mapping_code_reg[g]);
            assign is_lcd[g] = (fn == fn_lcd);
            assign is_analog[g] = (fn == fn_analog);
            assign is_mapped[g] = (fn == fn_mapped);
            always_comb
            begin
                pad_next.out[g] = 1'b0;
                pad_next.oe[g] = 1'b0;
                pad_next.in_enable[g] = 1'b1;
                gpio_in_next[g] = 1'b0;
                mapped_in_next[g] = 1'b0;
                case (fn)
                    fn_gpio:
                    begin
                        pad_next.out[g] = gpio_out[g];
                        pad_next.oe[g] = pin_direction_bit_reg[g];
                        gpio_in_next[g] = pad_in[g];
                    end
                    fn_mapped:
                    begin
                        pad_next.out[g] = mapped_drive.out[g];
                        pad_next.oe[g] = mapped_drive.oe[g];
                        mapped_in_next[g] = pad_in[g];
                    end
                    fn_analog:
                    begin
                        pad_next.oe[g] = 1'b0;
                        pad_next.in_enable[g] = 1'b0;
                    end
                    fn_lcd:
                    begin
                        pad_next.out[g] = lcd_segment_line[g];
                        pad_next.oe[g] = 1'b1;
                        pad_next.in_enable[g] = 1'b0;
                    end
                    default:
                    begin
                        pad_next.oe[g] = 1'b0;
                        pad_next.in_enable[g] = 1'b0;
                    end
                endcase
            end
            assign is_out[g] = pad_next.oe[g];
        end
    endgenerate

    // registered pad and peripheral side outputs
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pad <= '0;
            gpio_in <= '0;
            mapped_in <= '0;
        end
        else
        begin
            pad <= pad_next;
            gpio_in <= gpio_in_next;
            mapped_in <= mapped_in_next;
        end
    end

    // write channels held until both have arrived
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
        end
        else if (aw_held_reg && w_held_reg)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
        end
    end

    // next values of the holds and the response, for the registered readies
    always_comb
    begin
        aw_held_next = aw_held_reg;
        w_held_next = w_held_reg;
        bvalid_next = s_axi_bvalid;
        if (aw_held_reg && w_held_reg)
        begin
            aw_held_next = 1'b0;
            w_held_next = 1'b0;
            bvalid_next = 1'b1;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
                aw_held_next = 1'b1;
            if (s_axi_wvalid && s_axi_wready)
                w_held_next = 1'b1;
            if (s_axi_bready)
                bvalid_next = 1'b0;
        end
    end

    // readies low while a channel is held or the response waits
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end
        else
        begin
            s_axi_awready <= !aw_held_next && !bvalid_next;
            s_axi_wready <= !w_held_next && !bvalid_next;
        end
    end

    assign write_hit = map_hit(awaddr_reg, 1'b0);

    // write response
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= resp_okay;
        end
        else if (aw_held_reg && w_held_reg)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= write_hit ? resp_okay : resp_slverr;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // control registers, low byte lane only
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pin_direction_bit_reg <= dir_reset;
            pin_function_select_bit_reg <= sel_reset;
            lcd_segment_enable_reg <= lcd_reset;
            for (int i = 0; i < pin_count; i++)
                pin_mapping_code_reg[i] <= map_reset;
        end
        else if (aw_held_reg && w_held_reg && wstrb_reg[0])
        begin
            if (awaddr_reg == dir_offset)
                pin_direction_bit_reg <= wdata_reg[pin_count-1:0];
            if (awaddr_reg == sel_offset)
                pin_function_select_bit_reg <= wdata_reg[pin_count-1:0];
            if (awaddr_reg == lcd_offset)
                lcd_segment_enable_reg <= wdata_reg[pin_count-1:0];
            for (int i = 0; i < pin_count; i++)
                if (awaddr_reg == map0_offset + 12'(4 * i))
                    pin_mapping_code_reg[i] <= wdata_reg[code_width-1:0];
        end
    end

    always_comb
    begin
        read_word = '0;
        read_hit = map_hit(s_axi_araddr, 1'b1);
        if (s_axi_araddr == dir_offset)
            read_word[pin_count-1:0] = pin_direction_bit_reg;
        if (s_axi_araddr == sel_offset)
            read_word[pin_count-1:0] = pin_function_select_bit_reg;
        if (s_axi_araddr == lcd_offset)
            read_word[pin_count-1:0] = lcd_segment_enable_reg;
        for (int i = 0; i < pin_count; i++)
            if (s_axi_araddr == map0_offset + 12'(4 * i))
                read_word[code_width-1:0] = pin_mapping_code_reg[i];
        if (s_axi_araddr == state_offset)
        begin
            read_word[state_lcd_pos +: pin_count] = is_lcd;
            read_word[state_analog_pos +: pin_count] = is_analog;
            read_word[state_mapped_pos +: pin_count] = is_mapped;
            read_word[state_out_pos +: pin_count] = is_out;
        end
    end

    // read channel, two cycles from arvalid to the answer
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= resp_okay;
        end
        else if (s_axi_rvalid)
        begin
            s_axi_arready <= 1'b0;
            if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
        else if (s_axi_arvalid && !s_axi_arready)
            s_axi_arready <= 1'b1;
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= read_word;
            s_axi_rresp <= read_hit ? resp_okay : resp_slverr;
        end
    end

endmodule : port_one_low_pin_function_select

// ==== test/pad_model.sv ====
// pad model: a driven pin reads back its driver, a released one the outside level
module pad_model
(
    input wire pin_mux_pkg::pad_type pad,
    input wire logic [4:0] outside_level,
    output logic [4:0] pad_in
);
    timeunit 1ns;
    timeprecision 1ns;
    import pin_mux_pkg::*;
    always_comb
        for (int i = 0; i < pin_count; i++)
            pad_in[i] = pad.oe[i] ? pad.out[i] : outside_level[i];
endmodule : pad_model

// ==== test/pin_mux_assertions.sv ====
// checker of pin modes against a shadow of the control bits written over the bus
module pin_mux_assertions
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [4:0] gpio_out,
    input wire logic [4:0] gpio_in,
    input wire pin_mux_pkg::drive_type mapped_drive,
    input wire logic [4:0] mapped_in,
    input wire logic [4:0] lcd_segment_line,
    input wire pin_mux_pkg::pad_type pad,
    input wire logic [4:0] pad_in
);
    timeunit 1ns;
    timeprecision 1ns;
    import pin_mux_pkg::*;
    logic [4:0] dir_reg, sel_reg, lcd_reg, wd_reg;
    logic [4:0] map_reg [5];
    logic [11:0] wa_reg;
    logic we_reg, alive_reg;
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    always_ff @(posedge clock or negedge arst_n)
        if (!arst_n)
            alive_reg <= 1'b0;
        else
            alive_reg <= 1'b1;
    always_ff @(posedge clock)
    begin
        if (s_axi_awvalid && s_axi_awready)
            wa_reg <= s_axi_awaddr;
        if (s_axi_wvalid && s_axi_wready)
            {we_reg, wd_reg} <= {s_axi_wstrb[0], s_axi_wdata[4:0]};
    end
    // shadow moves when the response is taken, the edge the pads move
    always_ff @(posedge clock or negedge arst_n)
        if (!arst_n)
        begin
            {dir_reg, sel_reg, lcd_reg} <= '0;
            map_reg <= '{default: '0};
        end
        else if (s_axi_bvalid && s_axi_bready && s_axi_bresp == resp_okay && we_reg)
            case (wa_reg)
                dir_offset: dir_reg <= wd_reg;
                sel_offset: sel_reg <= wd_reg;
                lcd_offset: lcd_reg <= wd_reg;
                12'h00c, 12'h010, 12'h014, 12'h018, 12'h01c:
                    map_reg[wa_reg[4:2] - 3'd3] <= wd_reg;
                default: ;
            endcase
    property p_start;
        $rose(alive_reg) |-> pad.oe == 5'h00 && pad.in_enable == 5'h1f;
    endproperty
    a_start: assert property (p_start) else $error("pins not plain inputs after reset");
    for (genvar i = 0; i < pin_count; i++)
    begin : g_pin
        property p_gpio;
            alive_reg && !lcd_reg[i] && !sel_reg[i] |-> pad.oe[i] == dir_reg[i]
                && pad.in_enable[i] && gpio_in[i] == $past(pad_in[i]) && !mapped_in[i]
                && (!pad.oe[i] || pad.out[i] == $past(gpio_out[i]));
        endproperty
        property p_mapped_data;
            alive_reg && !lcd_reg[i] && sel_reg[i] && map_reg[i] != analog_code
                |-> mapped_in[i] == $past(pad_in[i]) && !gpio_in[i]
                && (!pad.oe[i] || pad.out[i] == $past(mapped_drive.out[i]));
        endproperty
        property p_mapped_dir;
            alive_reg && !lcd_reg[i] && sel_reg[i] && map_reg[i] != analog_code
                |-> pad.oe[i] == $past(mapped_drive.oe[i]);
        endproperty
        property p_analog;
            alive_reg && !lcd_reg[i] && sel_reg[i] && map_reg[i] == analog_code
                |-> !pad.oe[i] && !pad.in_enable[i] && !gpio_in[i] && !mapped_in[i];
        endproperty
        property p_lcd;
            alive_reg && lcd_reg[i] |-> pad.oe[i] && pad.out[i] == $past(lcd_segment_line[i]);
        endproperty
        a_gpio: assert property (p_gpio) else $error("plain pin mismatch");
        a_mapped_data: assert property (p_mapped_data) else $error("mapped data mismatch");
        a_mapped_dir: assert property (p_mapped_dir) else $error("mapped direction mismatch");
        a_analog: assert property (p_analog) else $error("analog pin not isolated");
        a_lcd: assert property (p_lcd) else $error("segment pin mismatch");
    end
    c_lcd: cover property (alive_reg && lcd_reg != 5'h00);
    c_analog: cover property (alive_reg && sel_reg[2] && map_reg[2] == analog_code);
    c_err: cover property (s_axi_bvalid && s_axi_bresp == resp_slverr);
endmodule : pin_mux_assertions

bind port_one_low_pin_function_select pin_mux_assertions chk (.clock(clock), .arst_n(arst_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .gpio_out(gpio_out), .gpio_in(gpio_in),
    .mapped_drive(mapped_drive), .mapped_in(mapped_in), .lcd_segment_line(lcd_segment_line),
    .pad(pad), .pad_in(pad_in));

// ==== test/port_one_low_pin_function_select_tb.sv ====
// self-checking bench for the low-pin function selector
module port_one_low_pin_function_select_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import pin_mux_pkg::*;
    logic clock, arst_n, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [4:0] gpio_out, gpio_in, mapped_in, seg, lvl, pad_in;
    drive_type mdrv;
    pad_type pad;
    int miscompares, num_checks;
    port_one_low_pin_function_select dut (.clock(clock), .arst_n(arst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .gpio_out(gpio_out), .gpio_in(gpio_in), .mapped_drive(mdrv), .mapped_in(mapped_in),
        .lcd_segment_line(seg), .pad(pad), .pad_in(pad_in));
    pad_model far (.pad(pad), .outside_level(lvl), .pad_in(pad_in));
    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    task automatic stop_test();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic guard(int n);
        if (n >= 40)
        begin
            miscompares++;
            stop_test();
        end
    endtask : guard
    task automatic wr(logic [11:0] a, logic [31:0] d, logic [1:0] er);
        logic [2:0] hit;
        logic [1:0] r;
        int n;
        n = 0;
        @(posedge clock);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
        do
        begin
            @(negedge clock);
            hit = {awready, wready, bvalid};
            r = bresp;
            @(posedge clock);
            if (hit[2])
                awvalid <= 1'b0;
            if (hit[1])
                wvalid <= 1'b0;
            n++;
        end while (!hit[0] && n < 40);
        bready <= 1'b0;
        guard(n);
        chk("bresp", er, r);
    endtask : wr
    task automatic rd(logic [11:0] a, logic [31:0] ed, logic [1:0] er);
        logic [1:0] hit;
        logic [31:0] d;
        logic [1:0] r;
        int n;
        n = 0;
        @(posedge clock);
        {araddr, arvalid, rready} <= {a, 2'b11};
        do
        begin
            @(negedge clock);
            hit = {arready, rvalid};
            {d, r} = {rdata, rresp};
            @(posedge clock);
            if (hit[1])
                arvalid <= 1'b0;
            n++;
        end while (!hit[0] && n < 40);
        rready <= 1'b0;
        guard(n);
        chk("rdata", ed, d);
        chk("rresp", er, r);
    endtask : rd
    // pads follow the control bits one cycle later
    task automatic settle();
        repeat (2) @(posedge clock);
        @(negedge clock);
    endtask : settle
    task automatic t_reset();
        logic [11:0] offs [9] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010,
            12'h014, 12'h018, 12'h01c, 12'h020};
        settle();
        chk("oe", 5'h00, pad.oe);
        chk("in_enable", 5'h1f, pad.in_enable);
        foreach (offs[i])
            rd(offs[i], 32'h0, resp_okay);
    endtask : t_reset
    task automatic t_gpio();
        {lvl, gpio_out} <= {5'h15, 5'h0c};
        wr(dir_offset, 32'h0a, resp_okay);
        settle();
        chk("oe", 5'h0a, pad.oe);
        chk("out", 5'h08, pad.out & pad.oe);
        chk("gpio_in", 5'h1d, gpio_in);
    endtask : t_gpio
    task automatic t_mapped();
        @(posedge clock);
        mdrv <= {5'h1e, 5'h03};
        wr(12'h01c, 32'h1e, resp_okay);
        wr(sel_offset, 32'h1a, resp_okay);
        settle();
        chk("oe", 5'h02, pad.oe);
        chk("mapped_in", 5'h12, mapped_in);
        chk("gpio_in", 5'h05, gpio_in);
        @(posedge clock);
        mdrv.oe <= 5'h18;
        settle();
        chk("oe", 5'h18, pad.oe);
        chk("mapped_in", 5'h18, mapped_in);
    endtask : t_mapped
    task automatic t_analog();
        wr(dir_offset, 32'h1f, resp_okay);
        wr(12'h014, 32'h1f, resp_okay);
        wr(sel_offset, 32'h1e, resp_okay);
        settle();
        chk("oe", 5'h19, pad.oe);
        chk("in_enable", 5'h00, pad.in_enable & 5'h04);
        chk("inputs", 5'h00, (gpio_in | mapped_in) & 5'h04);
        rd(state_offset, 32'h191a_0400, resp_okay);
    endtask : t_analog
    task automatic t_lcd();
        seg <= 5'h01;
        wr(lcd_offset, 32'h05, resp_okay);
        settle();
        chk("oe", 5'h1d, pad.oe);
        chk("out", 5'h01, pad.out & 5'h05);
        @(posedge clock);
        seg <= 5'h04;
        settle();
        chk("out", 5'h04, pad.out & 5'h05);
    endtask : t_lcd
    task automatic t_bus();
        wr(12'h040, 32'h1f, resp_slverr);
        rd(12'h040, 32'h0, resp_slverr);
        wr(state_offset, 32'h1f, resp_slverr);
        wr(dir_offset, 32'hffff_ffe0, resp_okay);
        rd(dir_offset, 32'h0, resp_okay);
        wr(map0_offset + 12'h004, 32'h1f, resp_okay);
        rd(map0_offset + 12'h004, 32'h1f, resp_okay);
        wstrb <= 4'he;
        wr(lcd_offset, 32'h1f, resp_okay);
        wstrb <= 4'hf;
        rd(lcd_offset, 32'h05, resp_okay);
        arst_n <= 1'b0;
        @(posedge clock);
        arst_n <= 1'b1;
        rd(lcd_offset, 32'h0, resp_okay);
    endtask : t_bus
    initial
    begin
        {miscompares, num_checks} = '0;
        {arst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, gpio_out, seg, lvl, mdrv} = '0;
        wstrb = 4'hf;
        repeat (3) @(posedge clock);
        arst_n <= 1'b1;
        t_reset();
        t_gpio();
        t_mapped();
        t_analog();
        t_lcd();
        t_bus();
        stop_test();
    end
endmodule : port_one_low_pin_function_select_tb
